// ### scfg_pkg.sv
// Purpose: Shared constants for the serial channel configuration registers
// Assumes: 16-bit frames, command byte first, MSB first
// Notes: Offsets and field positions of the two control registers
package scfg_pkg;
   // ==========================================
   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 14;
   localparam int ADDR_HI = 13;
   localparam int ADDR_LO = 8;
   localparam logic [1:0] OPC_WRITE = 2'h0;
   // ==========================================
   // Register offsets
   localparam logic [5:0] ADDR_TWO_FIVE = 6'h01;
   localparam logic [5:0] ADDR_ONE_FOUR = 6'h02;
   localparam int REG_COUNT = 2;
   // ==========================================
   // Field positions
   localparam int PUMP_BIT = 7;
   localparam int HI_CH_HI = 6;
   localparam int HI_CH_LO = 4;
   localparam int BRIDGE_BIT = 3;
   localparam int LO_CH_HI = 2;
   localparam int LO_CH_LO = 0;
   // ==========================================
   // Reset values: pump kept on
   localparam logic [7:0] RST_TWO_FIVE = 8'h80;
   localparam logic [7:0] RST_ONE_FOUR = 8'h00;
   // ==========================================
   // Channel codes
   localparam logic [2:0] CODE_OFF = 3'h0;
   localparam logic [2:0] CODE_ON_FAST = 3'h1;
   localparam logic [2:0] CODE_ON_SLOW = 3'h2;
   localparam logic [2:0] CODE_ON_RECOV = 3'h3;
   localparam logic [2:0] CODE_PWM_FAST = 3'h5;
   localparam logic [2:0] CODE_PWM_SLOW = 3'h6;
   localparam logic [2:0] CODE_OFF_OL = 3'h7;
   typedef enum logic [1:0] {scfg_idle, scfg_shift, scfg_done} scfg_state_t;
endpackage

// ### scfg_chan_decode.sv
// Purpose: Decode one 3-bit channel configuration code
// Assumes: Codes as in the package
// Notes: Registered outputs
`timescale 1ns/100ps
module scfg_chan_decode (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Code and result
   input wire logic [2:0] code,
   output logic on,
   output logic pwm,
   output logic slow_slew,
   output logic recovery,
   output logic offstate_ol_en
);
   import scfg_pkg::*;
   logic next_on, next_pwm, next_slow, next_rec, next_ol;
   always_comb begin
      next_on = 1'b0;
      next_pwm = 1'b0;
      next_slow = 1'b0;
      next_rec = 1'b0;
      next_ol = 1'b0;
      unique case (code)
         CODE_OFF: next_ol = 1'b0;
         CODE_ON_FAST: next_on = 1'b1;
         CODE_ON_SLOW: begin
            next_on = 1'b1;
            next_slow = 1'b1;
         end
         CODE_ON_RECOV: begin
            next_on = 1'b1;
            next_slow = 1'b1;
            next_rec = 1'b1;
         end
         CODE_PWM_FAST: next_pwm = 1'b1;
         CODE_PWM_SLOW: begin
            next_pwm = 1'b1;
            next_slow = 1'b1;
            next_ol = 1'b1;
         end
         CODE_OFF_OL: begin
            next_slow = 1'b1;
            next_ol = 1'b1;
         end
         default: next_on = 1'b0;
      endcase
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         on <= 1'b0;
         pwm <= 1'b0;
         slow_slew <= 1'b0;
         recovery <= 1'b0;
         offstate_ol_en <= 1'b0;
      end else begin
         on <= next_on;
         pwm <= next_pwm;
         slow_slew <= next_slow;
         recovery <= next_rec;
         offstate_ol_en <= next_ol;
      end
   end
endmodule

// ### scfg_regs.sv
// Purpose: Serial write frames into two channel configuration registers
// Assumes: Serial pins synchronous to ref_clk
// Notes: Writes commit on chip select release after exactly 16 bits
// ==========================================
// Notes on behaviour
// - A write is a command byte (opcode in top two bits, address below) then a data byte.
// - Opcode zero with address two stores the data byte in the channel one/four register.
// - Opcode zero with address one stores the data byte in the channel two/five register.
// - The one/four register holds pump disable, channel four, bridge one/four, channel one.
// - The two/five register holds pump keep, channel five, bridge two/five, channel two.
// - The pump runs with keep at one and disable at zero, which are the reset values.
// - Code 001b turns a channel on, fast slew, no PWM, no recovery.
// - Code 010b turns a channel on, slow slew, no PWM, no recovery.
// - Code 000b keeps a channel off with off-state open-load check disabled.
// - Code 111b keeps a channel off with off-state open-load check enabled.
// - A bridge bit at one pairs its two channels, at zero it does not.
// - Bridged channel five off with check on and channel one on does not flag a pulled-up drain.
// - In that setting channel five is flagged when its drain stays below the threshold.
// - When both channels of a bridged pair are asked on, channel one or two wins and channel four or five stays off.
// - The pump stops only when keep is clear and disable is set together.
`timescale 1ns/100ps
module scfg_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Serial port
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   // Drain sense of channel five
   input wire logic drain_five_low,
   // Register contents
   output logic [7:0] channel_two_five_config,
   output logic [7:0] channel_one_four_config,
   // Channel drive
   output logic [5:0] chan_on,
   output logic [5:0] chan_pwm,
   output logic [5:0] chan_slow_slew,
   output logic [5:0] chan_recovery,
   output logic [5:0] chan_offstate_ol_en,
   output logic bridge_one_four,
   output logic bridge_two_five,
   output logic pump_run,
   output logic open_load_five
);
   import scfg_pkg::*;
   // ==========================================
   // Serial shift
   scfg_state_t state, next_state;
   logic [15:0] shreg, next_shreg;
   logic [4:0] bitcnt, next_bitcnt;
   logic sclk_d, next_sclk_d;
   logic [7:0] next_two_five, next_one_four;
   logic sclk_rise;
   assign sclk_rise = sclk & ~sclk_d;
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_sclk_d = sclk;
      next_two_five = channel_two_five_config;
      next_one_four = channel_one_four_config;
      unique case (state)
         scfg_idle: begin
            if (!cs_n) begin
               next_state = scfg_shift;
               next_bitcnt = 5'h00;
            end
         end
         scfg_shift: begin
            if (cs_n) begin
               next_state = scfg_done;
            end else if (sclk_rise) begin
               next_shreg = {shreg[14:0], sdi};
               if (bitcnt != 5'h1F) begin
                  next_bitcnt = bitcnt + 5'h01;
               end
            end
         end
         scfg_done: begin
            next_state = scfg_idle;
            if (bitcnt == 5'(FRAME_BITS) && shreg[OPC_HI:OPC_LO] == OPC_WRITE) begin
               if (shreg[ADDR_HI:ADDR_LO] == ADDR_TWO_FIVE) begin
                  next_two_five = shreg[7:0];
               end else if (shreg[ADDR_HI:ADDR_LO] == ADDR_ONE_FOUR) begin
                  next_one_four = shreg[7:0];
               end
            end
         end
         default: next_state = scfg_idle;
      endcase
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= scfg_idle;
         shreg <= 16'h0000;
         bitcnt <= 5'h00;
         sclk_d <= 1'b0;
         channel_two_five_config <= RST_TWO_FIVE;
         channel_one_four_config <= RST_ONE_FOUR;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         sclk_d <= next_sclk_d;
         channel_two_five_config <= next_two_five;
         channel_one_four_config <= next_one_four;
      end
   end
   // ==========================================
   // Channel decode, index 0 = channel one
   logic [2:0] codes [6];
   always_comb begin
      codes[0] = channel_one_four_config[LO_CH_HI:LO_CH_LO];
      codes[1] = channel_two_five_config[LO_CH_HI:LO_CH_LO];
      codes[2] = CODE_OFF;
      codes[3] = channel_one_four_config[HI_CH_HI:HI_CH_LO];
      codes[4] = channel_two_five_config[HI_CH_HI:HI_CH_LO];
      codes[5] = CODE_OFF;
   end
   logic [5:0] dec_on;
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_ch
         scfg_chan_decode u_dec (
            .ref_clk(ref_clk),
            .rst(rst),
            .code(codes[gi]),
            .on(dec_on[gi]),
            .pwm(chan_pwm[gi]),
            .slow_slew(chan_slow_slew[gi]),
            .recovery(chan_recovery[gi]),
            .offstate_ol_en(chan_offstate_ol_en[gi])
         );
      end
   endgenerate
   // ==========================================
   // Bridge, pump and open-load
   logic next_b14, next_b25, next_pump, next_ol5;
   logic [5:0] next_on;
   always_comb begin
      next_b14 = channel_one_four_config[BRIDGE_BIT];
      next_b25 = channel_two_five_config[BRIDGE_BIT];
      next_on = dec_on;
      if ((bridge_one_four || next_b14) && dec_on[0]) begin
         next_on[3] = 1'b0;
      end
      if ((bridge_two_five || next_b25) && dec_on[1]) begin
         next_on[4] = 1'b0;
      end
      next_pump = channel_two_five_config[PUMP_BIT] | ~channel_one_four_config[PUMP_BIT];
      next_ol5 = chan_offstate_ol_en[4] & ~chan_on[4] & drain_five_low;
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bridge_one_four <= 1'b0;
         bridge_two_five <= 1'b0;
         chan_on <= 6'h00;
         pump_run <= 1'b1;
         open_load_five <= 1'b0;
      end else begin
         bridge_one_four <= next_b14;
         bridge_two_five <= next_b25;
         chan_on <= next_on;
         pump_run <= next_pump;
         open_load_five <= next_ol5;
      end
   end
endmodule

// ### scfg_regs_asserts.sv
// Purpose: Port checks for scfg_regs
// Assumes: Registers update two cycles after chip select release
// Notes: Decode checks wait for a settled register value
`timescale 1ns/100ps
module scfg_regs_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Inputs
   input wire logic cs_n,
   input wire logic drain_five_low,
   // Outputs
   input wire logic [7:0] channel_two_five_config,
   input wire logic [7:0] channel_one_four_config,
   input wire logic [5:0] chan_on,
   input wire logic [5:0] chan_slow_slew,
   input wire logic [5:0] chan_offstate_ol_en,
   input wire logic bridge_two_five,
   input wire logic pump_run,
   input wire logic open_load_five
);
   wire [7:0] c25 = channel_two_five_config;
   wire [7:0] c14 = channel_one_four_config;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==========
   // Assertions
   property p_pump; pump_run == !(!$past(c25[7]) && $past(c14[7])); endproperty
   a_pump: assert property (p_pump) else $error("pump state");
   property p_brg; bridge_two_five == $past(c25[3]); endproperty
   a_brg: assert property (p_brg) else $error("bridge bit");
   property p_fast; (c14[2:0] == 3'h1)[*3] |-> chan_on[0] && !chan_slow_slew[0]; endproperty
   a_fast: assert property (p_fast) else $error("fast on");
   property p_slow; (c14[2:0] == 3'h2)[*3] |-> chan_on[0] && chan_slow_slew[0]; endproperty
   a_slow: assert property (p_slow) else $error("slow on");
   property p_off; (c14[6:4] == 3'h0)[*3] |-> !chan_on[3] && !chan_offstate_ol_en[3]; endproperty
   a_off: assert property (p_off) else $error("off");
   property p_offol; (c25[6:4] == 3'h7)[*3] |-> !chan_on[4] && chan_offstate_ol_en[4]; endproperty
   a_offol: assert property (p_offol) else $error("off check");
   property p_ollow; (c25[6:4] == 3'h7 && drain_five_low)[*4] |-> open_load_five; endproperty
   a_ollow: assert property (p_ollow) else $error("open load");
   property p_olup; (c25[6:4] == 3'h7 && !drain_five_low)[*4] |-> !open_load_five; endproperty
   a_olup: assert property (p_olup) else $error("false open load");
   property p_prio; bridge_two_five && chan_on[1] |-> !chan_on[4]; endproperty
   a_prio: assert property (p_prio) else $error("pair priority");
   property p_commit; !$stable(c14) |-> $past(cs_n, 2); endproperty
   a_commit: assert property (p_commit) else $error("early write");
   // ==========
   // Covers
   c_fast: cover property ((c14[2:0] == 3'h1)[*3]);
   c_olf: cover property (open_load_five);
   c_stop: cover property (!pump_run);
endmodule

// ### scfg_host.sv
// Purpose: Serial bus master model
// Assumes: Each clock level held two cycles
// Notes: Data line flips when released
`timescale 1ns/100ps
module scfg_host (
   // Clock
   input wire logic ref_clk,
   // Serial port
   output logic cs_n,
   output logic sclk,
   output logic sdi
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // Send n bits of f, MSB first, under low select
   task automatic send(input logic [15:0] f, input int n);
      @(posedge ref_clk);
      cs_n <= 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         sdi <= f[i];
         repeat (2) @(posedge ref_clk);
         sclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
         sclk <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
      cs_n <= 1'b1;
      sdi <= ~sdi;
      repeat (3) @(posedge ref_clk);
   endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for scfg_regs
// Assumes: Host model drives the serial pins
// Notes: Outputs sampled nine cycles after chip select release of each frame
`timescale 1ns/100ps
module tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic drain_five_low = 1'b0;
   logic cs_n, sclk, sdi, b14, b25, pump, olf;
   logic [7:0] c25, c14;
   logic [5:0] on, slow, ol_en, pwm, rec;
   int failures = 0;
   int n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   scfg_host u_scfg_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
   scfg_regs u_scfg_regs (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .drain_five_low(drain_five_low), .channel_two_five_config(c25),
      .channel_one_four_config(c14), .chan_on(on), .chan_pwm(pwm), .chan_slow_slew(slow),
      .chan_recovery(rec), .chan_offstate_ol_en(ol_en), .bridge_one_four(b14),
      .bridge_two_five(b25), .pump_run(pump), .open_load_five(olf));
   // ==========
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] f, input int n);
      u_scfg_host.send(f, n);
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   task automatic give_verdict;
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic t_writes;
      chk({c25[7], c14[7], 5'h00, pump}, 8'h81);
      wr(16'h0201, 16);
      chk(c14, 8'h01);
      chk({2'h0, on}, 8'h01);
      wr(16'h01A8, 16);
      chk(c25, 8'hA8);
      chk({b14, b25, on}, 8'h51);
      wr(16'h020A, 16);
      chk({b14, b25, slow}, 8'hD1);
   endtask
   task automatic t_refuse;
      wr(16'h0255, 15);
      chk(c14, 8'h0A);
      wr(16'h4255, 16);
      chk(c14, 8'h0A);
      wr(16'h0355, 16);
      chk({c25[7:4], c14[3:0]}, 8'hAA);
   endtask
   task automatic t_open_load;
      wr(16'h01F8, 16);
      chk({on, 2'h0}, {6'h01, 2'h0});
      chk({olf, 1'b0, ol_en}, 8'h10);
      @(posedge ref_clk);
      drain_five_low <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk({7'h00, olf}, 8'h01);
      @(posedge ref_clk);
      drain_five_low <= 1'b0;
   endtask
   task automatic t_pump_prio;
      wr(16'h0129, 16);
      chk({pump, 1'b0, on}, 8'h83);
      wr(16'h028A, 16);
      chk({7'h00, pump}, 8'h00);
      wr(16'h01A9, 16);
      chk({7'h00, pump}, 8'h01);
   endtask
   task automatic t_modes;
      wr(16'h0263, 16);
      chk({2'h0, pwm}, 8'h08);
      chk({2'h0, rec}, 8'h01);
      chk({2'h0, ol_en}, 8'h08);
      wr(16'h0255, 16);
      chk({2'h0, pwm}, 8'h09);
      chk({2'h0, slow}, 8'h10);
      chk({2'h0, on}, 8'h02);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      t_writes;
      t_refuse;
      t_open_load;
      t_pump_prio;
      t_modes;
      give_verdict;
   end
   initial begin
      #200000;
      failures++;
      give_verdict;
   end
endmodule
bind scfg_regs scfg_regs_asserts u_scfg_regs_asserts (.ref_clk, .rst, .cs_n, .drain_five_low,
   .channel_two_five_config, .channel_one_four_config, .chan_on, .chan_slow_slew,
   .chan_offstate_ol_en, .bridge_two_five, .pump_run, .open_load_five);
